// ---- remote_control_pin_logic.sv ----
// Functional notes
// - Low strap high makes lines 0-3 inputs
// - High strap high makes lines 4-7 inputs
// - Sleep request low halts all function
// - Toggle select high: command toggles output
// - Toggle select low: output follows reception
// - Reset input low resets the device
// - Receive amp enable high while receiving
// - Transmit amp enable high while transmitting
// - Reply enable high: answer valid commands
// - Bind input pairs; press sequence restores factory
// - Reply received output on peer reply
// - Indicator flash length encodes state
// - Sender line high drives receiver line high
// - Reply output held 100ms, restarted
// - All inputs: sender only, sleeps until high
// - Send command every 13.33ms while input high
//
// Our own choices: register access over AXI4-Lite and the register offsets.
module remote_control_pin_logic #(
  parameter int unsigned REPLY_HOLD_CYC  = rc_pin_pkg::REPLY_HOLD_CYC,
  parameter int unsigned TX_PERIOD_CYC   = rc_pin_pkg::TX_PERIOD_CYC,
  parameter int unsigned DEBOUNCE_CYC    = rc_pin_pkg::DEBOUNCE_CYC,
  parameter int unsigned FLASH_SHORT_CYC = rc_pin_pkg::FLASH_SHORT_CYC,
  parameter int unsigned FLASH_LONG_CYC  = rc_pin_pkg::FLASH_LONG_CYC,
  parameter int unsigned PAIR_WINDOW_CYC = rc_pin_pkg::PAIR_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Strap and control pins
  input  wire logic        low_group_direction_strap_i,
  input  wire logic        high_group_direction_strap_i,
  input  wire logic        sleep_n_i,
  input  wire logic        toggle_select_i,
  input  wire logic        reply_enable_i,
  input  wire logic        bind_request_i,
  // Status line pins
  input  wire logic [7:0]  status_lines_i,
  output logic      [7:0]  status_lines_o,
  output logic      [7:0]  status_lines_oe_o,
  // Amplifiers and indicators
  output logic             rx_amp_enable_o,
  output logic             tx_amp_enable_o,
  output logic             reply_received_o,
  output logic             activity_indicator_o,
  // Radio core side: outgoing control and reply
  output logic             tx_cmd_valid_o,
  output logic      [7:0]  tx_cmd_lines_o,
  output logic             tx_reply_valid_o,
  // Radio core side: incoming command, reply, transmitter busy
  input  wire logic        rx_cmd_valid_i,
  input  wire logic [7:0]  rx_cmd_lines_i,
  input  wire logic        rx_reply_valid_i,
  input  wire logic        tx_busy_i,
  // Interrupt
  output logic             irq_o,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int unsigned NPIN = 14;
  localparam int unsigned IW   = rc_pin_pkg::IRQ_W;

  // Debounced pins: lines, two straps, sleep, toggle, reply, bind
  logic [NPIN-1:0] clean;
  sync_debounce #(
    .WIDTH  (NPIN),
    .CYCLES (DEBOUNCE_CYC)
  ) u_pins (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .raw_i   ({bind_request_i, reply_enable_i, toggle_select_i, sleep_n_i,
               high_group_direction_strap_i, low_group_direction_strap_i,
               status_lines_i}),
    .clean_o (clean)
  );

  wire [7:0] lines_in   = clean[7:0];
  wire       strap_lo   = clean[8];
  wire       strap_hi   = clean[9];
  wire       awake      = clean[10];
  wire       toggle_mode = clean[11];
  wire       reply_en   = clean[12];
  wire       bind_lvl   = clean[13];

  // Direction mask: one where a line is an input
  wire [7:0] in_mask  = {{4{strap_hi}}, {4{strap_lo}}};
  wire       any_out  = ~&in_mask;
  wire       any_high = |(lines_in & in_mask);
  wire       sender_only = &in_mask;

  // Registers
  logic [31:0]   ctrl_reg;
  logic [IW-1:0] irq_reg;
  logic [IW-1:0] irq_next;
  logic [IW-1:0] mask_reg;
  logic [7:0]    out_reg;     // Stored output state
  logic [7:0]    last_rx_reg; // Last received command lines
  logic          bind_d_reg;
  logic [2:0]    press_reg;
  logic          reply_pend_reg;

  wire rx_armed = ctrl_reg[rc_pin_pkg::CTRL_RX_BIT];
  wire bound    = ctrl_reg[rc_pin_pkg::CTRL_BOUND_BIT];

  // Send timer; one short, as each restart costs a cycle
  logic tick_busy;
  logic tick_done;
  wire  tx_active = awake & any_high;
  interval_timer #(
    .CYCLES (TX_PERIOD_CYC - 1)
  ) u_tick (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (tx_active & ~tick_busy),
    .stop_i  (~tx_active),
    .busy_o  (tick_busy),
    .done_o  (tick_done)
  );

  // Reply hold timer
  logic hold_busy;
  wire  reply_evt = awake & rx_reply_valid_i & reply_pend_reg;
  interval_timer #(
    .CYCLES (REPLY_HOLD_CYC)
  ) u_hold (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (reply_evt),
    .stop_i  (~awake),
    .busy_o  (hold_busy),
    .done_o  ()
  );

  // Pairing window timer; counts presses for factory restore
  logic win_busy;
  wire  bind_rise = awake & bind_lvl & ~bind_d_reg;
  interval_timer #(
    .CYCLES (PAIR_WINDOW_CYC)
  ) u_win (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (bind_rise & ~win_busy),
    .stop_i  (~awake),
    .busy_o  (win_busy),
    .done_o  ()
  );

  wire factory_evt = bind_rise & win_busy &
                     (press_reg == rc_pin_pkg::FACTORY_PRESSES - 3'h1);
  wire pair_evt    = bind_rise & ~win_busy;

  // Command acceptance only from a bound peer while receiving
  wire cmd_ok   = awake & rx_armed & bound & any_out & rx_cmd_valid_i;
  wire [7:0] cmd_rise = rx_cmd_lines_i & ~last_rx_reg & ~in_mask;

  // Sending: first command on activation, then each period
  wire send_now = tx_active & (~tick_busy | tick_done);
  assign tx_cmd_valid_o   = send_now;
  assign tx_cmd_lines_o   = (lines_in & in_mask) | (out_reg & ~in_mask);
  assign tx_reply_valid_o = cmd_ok & reply_en;

  // Output state: toggled or momentary
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_reg     <= 8'h00;
      last_rx_reg <= 8'h00;
    end else if (!awake) begin
      out_reg     <= 8'h00;
      last_rx_reg <= 8'h00;
    end else if (cmd_ok) begin
      last_rx_reg <= rx_cmd_lines_i;
      if (toggle_mode) begin
        out_reg <= out_reg ^ cmd_rise;
      end else begin
        out_reg <= rx_cmd_lines_i & ~in_mask;
      end
    end else if (!toggle_mode && !rx_armed) begin
      out_reg     <= 8'h00;
      last_rx_reg <= 8'h00;
    end
  end

  // Pins: drive only lines that are outputs
  assign status_lines_o    = out_reg & ~in_mask;
  assign status_lines_oe_o = ~in_mask;

  // Amplifier enables; a sender-only unit listens only from its first send until sleep
  assign tx_amp_enable_o  = awake & (tx_busy_i | send_now);
  assign rx_amp_enable_o  = awake & ~tx_amp_enable_o & rx_armed &
                            (~sender_only | reply_pend_reg);
  assign reply_received_o = hold_busy;

  // Pairing press counter and reply expectation
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bind_d_reg     <= 1'b0;
      press_reg      <= 3'h0;
      reply_pend_reg <= 1'b0;
    end else begin
      bind_d_reg <= bind_lvl;
      if (!win_busy && !bind_rise) begin
        press_reg <= 3'h0;
      end else if (bind_rise) begin
        press_reg <= factory_evt ? 3'h0 : press_reg + 3'h1;
      end
      if (send_now) begin
        reply_pend_reg <= 1'b1;
      end else if (!awake) begin
        reply_pend_reg <= 1'b0;
      end
    end
  end

  // Indicator: flash length chosen by state
  rc_pin_pkg::ind_state_type ind_state;
  assign ind_state = !awake        ? rc_pin_pkg::IND_IDLE :
                     win_busy      ? rc_pin_pkg::IND_PAIR :
                     tx_active     ? rc_pin_pkg::IND_TX   :
                     cmd_ok        ? rc_pin_pkg::IND_RX   :
                                     rc_pin_pkg::IND_IDLE;
  logic flash_busy;
  interval_timer #(
    .CYCLES (FLASH_SHORT_CYC)
  ) u_flash_s (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (ind_state == rc_pin_pkg::IND_RX ||
              (ind_state == rc_pin_pkg::IND_TX && send_now)),
    .stop_i  (~awake),
    .busy_o  (flash_busy),
    .done_o  ()
  );
  logic flash_long;
  interval_timer #(
    .CYCLES (FLASH_LONG_CYC)
  ) u_flash_l (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (pair_evt | factory_evt),
    .stop_i  (~awake),
    .busy_o  (flash_long),
    .done_o  ()
  );
  assign activity_indicator_o = flash_busy | flash_long;

  // Interrupt status: set wins over write-one clear
  wire [IW-1:0] irq_set = {factory_evt, pair_evt, send_now, reply_evt, cmd_ok};
  wire          wr_go;
  wire [7:0]    wr_addr;
  assign irq_next = (irq_reg & ~((wr_go && wr_addr == rc_pin_pkg::ADDR_IRQ) ?
                     s_axi_wdata[IW-1:0] : '0)) | irq_set;
  assign irq_o    = |(irq_reg & mask_reg);

  // AXI write: take address and data together when both offered
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_go         = s_axi_awready;
  assign wr_addr       = s_axi_awaddr;
  wire wr_map = wr_addr == rc_pin_pkg::ADDR_CTRL ||
                wr_addr == rc_pin_pkg::ADDR_IRQ  ||
                wr_addr == rc_pin_pkg::ADDR_MASK;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg     <= rc_pin_pkg::CTRL_RESET;
      mask_reg     <= rc_pin_pkg::MASK_RESET;
      irq_reg      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      irq_reg <= irq_next;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
        if (wr_addr == rc_pin_pkg::ADDR_CTRL && s_axi_wstrb[0]) begin
          ctrl_reg[7:0] <= s_axi_wdata[7:0];
        end
        if (wr_addr == rc_pin_pkg::ADDR_MASK && s_axi_wstrb[0]) begin
          mask_reg <= s_axi_wdata[IW-1:0];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (factory_evt) begin
        ctrl_reg <= rc_pin_pkg::CTRL_RESET;
      end
    end
  end

  // AXI read: one cycle after address accepted
  assign s_axi_arready = ~s_axi_rvalid;
  logic [31:0] rd_mux;
  logic        rd_map;
  always_comb begin
    rd_map = 1'b1;
    case (s_axi_araddr)
      rc_pin_pkg::ADDR_CTRL:   rd_mux = ctrl_reg;
      rc_pin_pkg::ADDR_STATUS: rd_mux = {16'h0000, status_lines_oe_o,
                                         lines_in};
      rc_pin_pkg::ADDR_IRQ:    rd_mux = {27'h0000000, irq_reg};
      rc_pin_pkg::ADDR_MASK:   rd_mux = {27'h0000000, mask_reg};
      rc_pin_pkg::ADDR_RXCMD:  rd_mux = {24'h000000, out_reg};
      rc_pin_pkg::ADDR_TXCMD:  rd_mux = {24'h000000, tx_cmd_lines_o};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- rc_pin_pkg.sv ----
package rc_pin_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 100_000_000;

  // Times in microseconds, send period in nanoseconds
  localparam int unsigned REPLY_HOLD_US = 100_000; // 100 ms
  localparam int unsigned TX_PERIOD_NS  = 13_330_000; // 13.33 ms
  localparam int unsigned DEBOUNCE_US   = 1_000;

  // Derived cycle counts
  localparam int unsigned REPLY_HOLD_CYC = REPLY_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TX_PERIOD_CYC  = TX_PERIOD_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * (CLK_HZ / 1_000_000);

  // Indicator flash lengths in microseconds
  localparam int unsigned FLASH_SHORT_US = 50_000;
  localparam int unsigned FLASH_LONG_US  = 400_000;
  localparam int unsigned FLASH_SHORT_CYC = FLASH_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FLASH_LONG_CYC  = FLASH_LONG_US * (CLK_HZ / 1_000_000);

  // Pairing: this many presses within the window restore factory settings
  localparam logic [2:0] FACTORY_PRESSES = 3'h3;
  localparam int unsigned PAIR_WINDOW_US = 2_000_000;
  localparam int unsigned PAIR_WINDOW_CYC = PAIR_WINDOW_US * (CLK_HZ / 1_000_000);

  // Register map (AXI4-Lite byte addresses)
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ     = 8'h08;
  localparam logic [7:0] ADDR_MASK    = 8'h0c;
  localparam logic [7:0] ADDR_RXCMD   = 8'h10;
  localparam logic [7:0] ADDR_TXCMD   = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_RX_BIT   = 0; // Receiver armed
  localparam int unsigned CTRL_BOUND_BIT = 1; // Peer bound

  // Interrupt bit positions
  localparam int unsigned IRQ_RX_BIT     = 0;
  localparam int unsigned IRQ_REPLY_BIT  = 1;
  localparam int unsigned IRQ_TX_BIT     = 2;
  localparam int unsigned IRQ_PAIR_BIT   = 3;
  localparam int unsigned IRQ_FACTORY_BIT = 4;
  localparam int unsigned IRQ_W          = 5;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [IRQ_W-1:0] MASK_RESET = 5'h00;

  // Activity indicator states
  typedef enum logic [1:0] {
    IND_IDLE,
    IND_TX,
    IND_RX,
    IND_PAIR
  } ind_state_type;

endpackage

// ---- sync_debounce.sv ----
module sync_debounce #(
  parameter int unsigned WIDTH  = 1,
  parameter int unsigned CYCLES = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Raw pins and filtered levels
  input  wire logic [WIDTH-1:0] raw_i,
  output logic      [WIDTH-1:0] clean_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage
  logic [WIDTH-1:0] sync_reg; // Second stage

  // Two-flop synchroniser for every pin
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= raw_i;
      sync_reg <= meta_reg;
    end
  end

  // Each bit accepts a new level only once it held stable for CYCLES
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    logic [CW-1:0] cnt_reg;
    wire           differ = sync_reg[g] != clean_o[g];
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cnt_reg    <= '0;
        clean_o[g] <= 1'b0;
      end else if (!differ) begin
        cnt_reg <= '0;
      end else if (cnt_reg == CW'(CYCLES - 1)) begin
        cnt_reg    <= '0;
        clean_o[g] <= sync_reg[g];
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// ---- interval_timer.sv ----
module interval_timer #(
  parameter int unsigned CYCLES = 1000
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Start or restart, stop, running level and end pulse
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      busy_o,
  output logic      done_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_reg; // Cycles left

  // A start always reloads, so a repeated event extends the interval
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_reg <= CW'(CYCLES);
      end else if (stop_i) begin
        cnt_reg <= '0;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
        done_o  <= (cnt_reg == CW'(1));
      end
    end
  end

  assign busy_o = cnt_reg != '0;

endmodule

// ---- rc_pin_checker.sv ----
module rc_pin_checker (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Pins
  input  wire logic        sleep_n_i,
  input  wire logic [7:0]  status_lines_o,
  input  wire logic [7:0]  status_lines_oe_o,
  input  wire logic        tx_amp_enable_o,
  input  wire logic        reply_received_o,
  // Radio core side
  input  wire logic        tx_cmd_valid_o,
  input  wire logic        tx_reply_valid_o,
  input  wire logic        rx_cmd_valid_i,
  input  wire logic        rx_reply_valid_i,
  input  wire logic        tx_busy_i,
  // Bus handshakes
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Steps of a bus access and of a reply
  sequence wr_taken;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  sequence reply_seen;
    rx_reply_valid_i ##1 reply_received_o;
  endsequence
  // Input lines are never driven
  chk_out_masked: assert property (
    (status_lines_o & ~status_lines_oe_o) == 8'h00)
    else $error("driven value on an input line");
  // Long sleep stops sending
  chk_sleep_quiet: assert property (
    !sleep_n_i [*8] |-> !tx_cmd_valid_o) else $error("send while asleep");
  chk_reply_gate: assert property (
    tx_reply_valid_o |-> rx_cmd_valid_i) else $error("reply without command");
  chk_tx_amp: assert property (
    tx_busy_i |-> tx_amp_enable_o) else $error("tx amp off while busy");
  chk_reply_cause: assert property (
    $rose(reply_received_o) |-> $past(rx_reply_valid_i))
    else $error("reply output without reply");
  chk_reply_hold: assert property (
    reply_seen |=> reply_received_o [*8]) else $error("reply output short");
  // Sends are spaced, never back to back
  chk_tx_spacing: assert property (
    tx_cmd_valid_o |=> !tx_cmd_valid_o [*8]) else $error("sends too close");
  chk_wr_answer: assert property (
    wr_taken |=> s_axi_bvalid) else $error("write not answered");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
  chk_rd_answer: assert property (
    rd_taken |=> s_axi_rvalid) else $error("read not answered");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data lost");
endmodule

bind remote_control_pin_logic rc_pin_checker i_rc_pin_checker (.*);

// ---- rc_peer_model.sv ----
module rc_peer_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Bench controls
  input  wire logic       cmd_go_i,
  input  wire logic [7:0] cmd_lines_i,
  input  wire logic       ack_on_i,
  input  wire logic [3:0] lag_i,
  // Device side
  input  wire logic       tx_cmd_valid_i,
  output logic            rx_cmd_valid_o,
  output logic      [7:0] rx_cmd_lines_o,
  output logic            rx_reply_valid_o,
  output logic            tx_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] wait_cnt; // Cycles until our reply
  logic [1:0] busy_cnt; // Air time of one message
  assign tx_busy_o = (busy_cnt != 2'h0);
  // Idle lines show the inverse, so stale data cannot match by luck
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_cmd_valid_o <= 1'b0;
      rx_cmd_lines_o <= 8'h00;
      rx_reply_valid_o <= 1'b0;
      wait_cnt <= 5'h00;
      busy_cnt <= 2'h0;
    end else begin
      rx_cmd_valid_o <= cmd_go_i;
      rx_cmd_lines_o <= cmd_go_i ? cmd_lines_i : ~rx_cmd_lines_o;
      // Answer each send after a chosen lag, prompt or slow
      rx_reply_valid_o <= ack_on_i && (wait_cnt == 5'h01);
      if (tx_cmd_valid_i) begin
        wait_cnt <= {1'b0, lag_i} + 5'h01;
        busy_cnt <= 2'h3;
      end else begin
        wait_cnt <= (wait_cnt != 5'h00) ? wait_cnt - 5'h01 : 5'h00;
        busy_cnt <= (busy_cnt != 2'h0) ? busy_cnt - 2'h1 : 2'h0;
      end
    end
  end
endmodule

// ---- remote_control_pin_logic_test.sv ----
module remote_control_pin_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned HOLD = 50; // Shortened reply hold
  localparam int unsigned PER  = 20; // Shortened send period
  typedef struct packed {
    logic       t; // Toggle select
    logic       a; // Reply enable
    logic [7:0] l; // Received lines
    logic [7:0] o; // Expected driven lines
    logic       r; // Expected reply
  } row_type;
  // Toggle rows first, then momentary ones; lines 0-3 are inputs
  row_type rows [6] = '{'{1'b1, 1'b1, 8'h10, 8'h10, 1'b1},
    '{1'b1, 1'b1, 8'h10, 8'h10, 1'b1}, '{1'b1, 1'b0, 8'h00, 8'h10, 1'b0},
    '{1'b1, 1'b1, 8'h30, 8'h20, 1'b1}, '{1'b0, 1'b1, 8'hff, 8'hf0, 1'b1},
    '{1'b0, 1'b0, 8'h50, 8'h50, 1'b0}};
  logic clk_i, nrst_i, low_group_direction_strap_i;
  logic high_group_direction_strap_i, sleep_n_i, toggle_select_i;
  logic reply_enable_i, bind_request_i, rx_amp_enable_o, tx_amp_enable_o;
  logic reply_received_o, activity_indicator_o, tx_cmd_valid_o;
  logic tx_reply_valid_o, rx_cmd_valid_i, rx_reply_valid_i, tx_busy_i, irq_o;
  logic [7:0] status_lines_i, status_lines_o, status_lines_oe_o;
  logic [7:0] tx_cmd_lines_o, rx_cmd_lines_i, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_wstrb, lag;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [7:0]  cmd_lines, txl;
  logic        cmd_go, ack_on, rep;
  int cyc, err_total, checked, txn, gap, last_tx, last_ack, hold, run, lrun;
  int tx_run;
  remote_control_pin_logic #(.REPLY_HOLD_CYC(HOLD), .TX_PERIOD_CYC(PER),
    .DEBOUNCE_CYC(2), .FLASH_SHORT_CYC(5), .FLASH_LONG_CYC(10),
    .PAIR_WINDOW_CYC(40)) i_remote_control_pin_logic (.*);
  rc_peer_model i_rc_peer_model (.clk_i(clk_i), .nrst_i(nrst_i),
    .cmd_go_i(cmd_go), .cmd_lines_i(cmd_lines), .ack_on_i(ack_on),
    .lag_i(lag), .tx_cmd_valid_i(tx_cmd_valid_o),
    .rx_cmd_valid_o(rx_cmd_valid_i), .rx_cmd_lines_o(rx_cmd_lines_i),
    .rx_reply_valid_o(rx_reply_valid_i), .tx_busy_o(tx_busy_i));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task print_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts are bench integers, judged against a window
  task cmp_rng(input int v, input int lo, input int hi);
    checked++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  // Watchdog and monitors on one edge
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      print_verdict();
    end
    if (tx_cmd_valid_o) begin
      txn++;
      gap = cyc - last_tx;
      last_tx = cyc;
      txl = tx_cmd_lines_o;
    end
    if (rx_reply_valid_i) last_ack = cyc;
    if (reply_received_o) hold = cyc - last_ack;
    if (activity_indicator_o) run++;
    else if (run != 0) begin
      lrun = run;
      run = 0;
    end
  end
  // Address and data go out together; each is dropped once taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Peer sends one command; the reply pulse is read mid-cycle
  task send_cmd(input logic [7:0] l);
    @(posedge clk_i);
    cmd_go <= 1'b1;
    cmd_lines <= l;
    @(posedge clk_i);
    cmd_go <= 1'b0;
    @(negedge clk_i);
    rep = tx_reply_valid_o;
    repeat (3) @(posedge clk_i);
  endtask
  task press(input int n);
    repeat (n) begin
      bind_request_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      bind_request_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
  initial begin
    {nrst_i, high_group_direction_strap_i, toggle_select_i, reply_enable_i,
     bind_request_i, cmd_go, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
     s_axi_arvalid, s_axi_rready} = '0;
    {low_group_direction_strap_i, sleep_n_i, ack_on} = 3'h7;
    {status_lines_i, cmd_lines, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, lag} = {32'h0, 4'hf, 4'h3};
    {cyc, err_total, checked, txn, gap, last_tx, last_ack} = '0;
    {hold, run, lrun, tx_run} = '0;
    repeat (6) @(posedge clk_i);
    cmp({reply_received_o, irq_o, tx_cmd_valid_o}, 3'h0);
    nrst_i <= 1'b1;
    axi_rd(rc_pin_pkg::ADDR_CTRL);
    cmp(rd, rc_pin_pkg::CTRL_RESET);
    axi_rd(8'h20);
    cmp(rsp, 2'h2);
    cmp(rd, 32'h0);
    axi_wr(rc_pin_pkg::ADDR_CTRL, 32'h3);
    cmp(rsp, 2'h0);
    repeat (6) @(posedge clk_i);
    cmp(status_lines_oe_o, 8'hf0);
    cmp(rx_amp_enable_o, 1'b1);
    foreach (rows[k]) begin
      toggle_select_i <= rows[k].t;
      reply_enable_i <= rows[k].a;
      repeat (6) @(posedge clk_i);
      send_cmd(rows[k].l);
      cmp(rep, rows[k].r);
      cmp(status_lines_o, rows[k].o);
    end
    // Command event raises irq only once unmasked, and W1C clears it
    axi_rd(rc_pin_pkg::ADDR_IRQ);
    cmp(rd[4:0], 5'h01);
    cmp(irq_o, 1'b0);
    axi_wr(rc_pin_pkg::ADDR_MASK, 32'h1);
    cmp(irq_o, 1'b1);
    axi_wr(rc_pin_pkg::ADDR_IRQ, 32'h1);
    cmp(irq_o, 1'b0);
    // Disarming the receiver drops the amp and momentary outputs
    axi_wr(rc_pin_pkg::ADDR_CTRL, 32'h2);
    repeat (2) @(posedge clk_i);
    cmp({rx_amp_enable_o, status_lines_o}, 9'h000);
    // Held input: periodic sends, replies keep the output up
    txn = 0;
    status_lines_i <= 8'h01;
    repeat (70) @(posedge clk_i);
    cmp_rng(txn, 3, 4);
    cmp(gap, PER);
    cmp(txl[3:0], 4'h1);
    cmp(reply_received_o, 1'b1);
    tx_run = lrun;
    status_lines_i <= 8'h00;
    repeat (100) @(posedge clk_i);
    cmp_rng(hold, HOLD - 1, HOLD + 1);
    cmp(reply_received_o, 1'b0);
    // One press pairs; three quick presses restore defaults
    axi_wr(rc_pin_pkg::ADDR_IRQ, 32'h1f);
    press(1);
    repeat (60) @(posedge clk_i);
    axi_rd(rc_pin_pkg::ADDR_IRQ);
    cmp(rd[3], 1'b1);
    cmp(lrun > tx_run, 1'b1);
    axi_wr(rc_pin_pkg::ADDR_IRQ, 32'h1f);
    press(3);
    axi_rd(rc_pin_pkg::ADDR_IRQ);
    cmp(rd[4], 1'b1);
    axi_rd(rc_pin_pkg::ADDR_CTRL);
    cmp(rd, rc_pin_pkg::CTRL_RESET);
    // Asleep nothing is sent; a one-cycle glitch is filtered out
    sleep_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    txn = 0;
    status_lines_i <= 8'h01;
    repeat (60) @(posedge clk_i);
    cmp(txn, 0);
    status_lines_i <= 8'h00;
    sleep_n_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    status_lines_i <= 8'h01;
    @(posedge clk_i);
    status_lines_i <= 8'h00;
    repeat (30) @(posedge clk_i);
    cmp(txn, 0);
    // Reset in mid-run restores defaults
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp({status_lines_o, reply_received_o, irq_o}, 10'h000);
    nrst_i <= 1'b1;
    axi_rd(rc_pin_pkg::ADDR_MASK);
    cmp(rd[4:0], rc_pin_pkg::MASK_RESET);
    print_verdict();
  end
endmodule
